//--- dv/dma_ctrl_status_sva.sv
`timescale 1ns/1ps
`default_nettype none
// pin-level relations of the register bus and the interrupt outputs
module dma_ctrl_status_chk (
  input wire logic CLK_SYS,
  input wire logic RST_N,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [31:0] PADDR,
  input wire logic [31:0] PWDATA,
  input wire logic PREADY,
  input wire logic [31:0] PRDATA,
  input wire logic PSLVERR,
  input wire dma_pkg::lane_t LANE,
  input wire logic ENGINE_ENABLE,
  input wire logic TABLE_WALK,
  input wire logic DIRECTION,
  input wire logic [2:0] TABLE_FC,
  input wire logic [31:0] HOLD_DATA,
  input wire logic IRQ_REQ,
  input wire logic [2:0] IRQ_LEVEL
);
  // helpers so $past sees plain signals
  wire logic wr_done = PSEL && PENABLE && PREADY && PWRITE;
  wire logic [2:0] wd3 = PWDATA[2:0];
  wire logic [31:0] lane_data = LANE.data;
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (!RST_N);
  a_ready_wait: assert property (
    PSEL && PENABLE && !$past(PENABLE) |-> !PREADY ##1 PREADY) else $error("ready late");
  a_ready_pulse: assert property (
    PREADY |=> !PREADY) else $error("ready held");
  a_rdata_idle: assert property (
    !PREADY |-> PRDATA == 32'h0) else $error("read data outside answer");
  a_rdata_byte: assert property (
    PREADY |-> PRDATA[31:8] == 24'h0 && (!PSLVERR || PRDATA == 32'h0)) else $error("bad rdata");
  a_ctrl_write: assert property (
    wr_done && PADDR == 32'hFFF84084 |=> {DIRECTION, TABLE_WALK, ENGINE_ENABLE} == $past(wd3))
    else $error("control bits not taken");
  a_fc_write: assert property (
    wr_done && PADDR == 32'hFFF84094 |=> TABLE_FC == $past(wd3)) else $error("fc not taken");
  a_level_quiet: assert property (
    !IRQ_REQ |-> IRQ_LEVEL == 3'h0) else $error("level without request");
  a_level_nonzero: assert property (
    IRQ_REQ |-> IRQ_LEVEL != 3'h0) else $error("request at level zero");
  a_hold_load: assert property (
    ENGINE_ENABLE && LANE.wr == 4'hF |=> HOLD_DATA == $past(lane_data)) else $error("hold");
endmodule // dma_ctrl_status_chk
bind dma_ctrl_status dma_ctrl_status_chk u_chk (.CLK_SYS(CLK_SYS), .RST_N(RST_N),
  .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA),
  .PREADY(PREADY), .PRDATA(PRDATA), .PSLVERR(PSLVERR), .LANE(LANE),
  .ENGINE_ENABLE(ENGINE_ENABLE), .TABLE_WALK(TABLE_WALK), .DIRECTION(DIRECTION),
  .TABLE_FC(TABLE_FC), .HOLD_DATA(HOLD_DATA), .IRQ_REQ(IRQ_REQ), .IRQ_LEVEL(IRQ_LEVEL));
`default_nettype wire

//--- dv/dma_ctrl_status_tb.sv
`timescale 1ns/1ps
`default_nettype none
module dma_ctrl_status_tb;
  localparam logic [31:0] A_IC = 32'hFFF84080;
  localparam logic [31:0] A_CS = 32'hFFF84084;
  localparam logic [31:0] A_HS = 32'hFFF8408C;
  localparam logic [31:0] A_FC = 32'hFFF84094;
  localparam logic [31:0] A_GC = 32'hFFF8409C;
  localparam logic [7:0] IV [4] = '{8'h0D, 8'h08, 8'h0B, 8'h0E};
  localparam logic [7:0] GV [4] = '{8'h10, 8'h10, 8'h00, 8'h10};
  localparam logic [7:0] FV [4] = '{8'h01, 8'h02, 8'h05, 8'h06};
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] paddr = 32'h0;
  logic [31:0] pwdata = 32'h0;
  logic go = 1'b0;
  logic [1:0] kind = 2'h0;
  logic [31:0] arg = 32'h0;
  logic pready, pslverr, en, tw, dir, irq, e, x;
  logic [31:0] prdata, hold, q;
  logic [2:0] fc, lvl;
  dma_pkg::engine_evt_t evt;
  dma_pkg::lane_t lane;
  dma_pkg::step_t step;
  int fail_count = 0;
  int n_compared = 0;
  int cyc = 0;
  always #20 clk = ~clk;
  dma_ctrl_status u_dut (.CLK_SYS(clk), .RST_N(rst_n), .PSEL(psel), .PENABLE(penable),
    .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PREADY(pready), .PRDATA(prdata),
    .PSLVERR(pslverr), .ENGINE_EVT(evt), .LANE(lane), .STEP(step), .ENGINE_ENABLE(en),
    .TABLE_WALK(tw), .DIRECTION(dir), .TABLE_FC(fc), .HOLD_DATA(hold), .IRQ_REQ(irq),
    .IRQ_LEVEL(lvl));
  dma_engine_model u_eng (.clk(clk), .go(go), .kind(kind), .arg(arg), .evt(evt),
    .lane(lane), .step(step));
  task automatic finish_test;
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      fail_count++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // one transfer; answer taken at the edge that samples ready high,
  // request released there, then one idle edge before the next setup
  task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rd(input logic [31:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    check(q, exp);
  endtask
  // engine pulse, then let it land in the status bits
  task automatic fire(input logic [1:0] k, input logic [31:0] v);
    go <= 1'b1;
    kind <= k;
    arg <= v;
    @(posedge clk);
    go <= 1'b0;
    repeat (2) @(posedge clk);
  endtask
  // hang guard: the whole sequence needs well under this many cycles
  always @(posedge clk) begin
    cyc++;
    if (cyc == 6000) begin
      fail_count++;
      finish_test();
    end
  end
  initial begin
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    rd(A_IC, 32'h0);
    rd(A_CS, 32'h0);
    rd(A_HS, 32'h0);
    rd(A_GC, 32'h0);
    wr(32'hFFF84088, 32'hFF);
    check({31'h0, e}, 32'h1);
    rd(32'hFFF84088, 32'h0);
    check({31'h0, e}, 32'h1);
    $display("reset and map test done");
    wr(A_CS, 32'hFF);
    rd(A_CS, 32'h7);
    check({29'h0, dir, tw, en}, 32'h7);
    wr(A_HS, 32'hFF);
    rd(A_HS, 32'h0);
    for (int i = 0; i < 5; i++) begin
      wr(A_CS, 32'h1);
      fire(2'h0, 32'h1 << i);
      wr(A_CS, 32'hF9);
      rd(A_CS, 32'h81 | (32'h40 >> i) & 32'h78);
      wr(A_CS, 32'h0);
      fire(2'h0, 32'h1 << i);
      rd(A_CS, 32'h0);
    end
    $display("status test done");
    wr(A_CS, 32'h1);
    fire(2'h1, 32'hF);
    check(hold, 32'hA1B2C3D4);
    fire(2'h2, 32'h5);
    for (int s = 0; s < 4; s++) begin
      fire(2'h3, 32'(s));
      rd(A_HS, (32'h10 << s) | 32'hA);
    end
    wr(A_CS, 32'h0);
    rd(A_HS, 32'h0);
    $display("holding test done");
    for (int j = 0; j < 4; j++) begin
      wr(A_CS, 32'h0);
      wr(A_GC, {24'h0, GV[j]});
      wr(A_IC, {24'h0, IV[j]});
      rd(A_IC, {24'h0, IV[j]});
      wr(A_CS, 32'h1);
      fire(2'h0, 32'h10);
      repeat (2) @(posedge clk);
      x = (IV[j][2:0] != 3'h0) && GV[j][4];
      check({28'h0, irq, lvl}, {28'h0, x, x ? IV[j][2:0] : 3'h0});
      rd(A_IC, {24'h0, IV[j]} | 32'h80);
      wr(A_IC, j[0] ? 32'h0 : {24'h0, IV[j]} | 32'h80);
      rd(A_IC, j[0] ? 32'h0 : {24'h0, IV[j]});
      check({31'h0, irq}, 32'h0);
    end
    $display("interrupt test done");
    for (int k = 0; k < 4; k++) begin
      wr(A_FC, 32'hF8 | {24'h0, FV[k]});
      check({29'h0, fc}, {24'h0, FV[k]});
      rd(A_FC, {24'h0, FV[k]});
    end
    $display("function code test done");
    // a reset in mid-run clears the control, interrupt, function code and gate registers again
    wr(A_CS, 32'h7);
    wr(A_IC, 32'h0F);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    rd(A_CS, 32'h0);
    rd(A_IC, 32'h0);
    rd(A_FC, 32'h0);
    rd(A_GC, 32'h0);
    check({29'h0, dir, tw, en}, 32'h0);
    $display("mid-run reset test done");
    finish_test();
  end
endmodule // dma_ctrl_status_tb
`default_nettype wire

//--- dv/dma_engine_model.sv
`timescale 1ns/1ps
`default_nettype none
// engine stand-in: one-cycle event, lane and step pulses on request
module dma_engine_model (
  input wire logic clk,
  input wire logic go,
  input wire logic [1:0] kind,
  input wire logic [31:0] arg,
  output dma_pkg::engine_evt_t evt,
  output dma_pkg::lane_t lane,
  output dma_pkg::step_t step
);
  // one process drives every output, so nothing has two drivers
  // idle lane data toggles so a stale byte never looks like a fresh load
  initial begin
    evt = '0;
    lane = '0;
    step = '0;
    forever begin
      @(posedge clk);
      evt <= '0;
      lane <= {8'h00, ~lane.data};
      step <= '0;
      if (go) begin
        case (kind)
          2'h0: evt <= arg[4:0];
          2'h1: lane <= {arg[3:0], 4'h0, 32'hA1B2C3D4};
          2'h2: lane <= {4'h0, arg[3:0], ~lane.data};
          default: step <= {1'b1, arg[1:0]};
        endcase
      end
    end
  end
endmodule // dma_engine_model
`default_nettype wire

//--- rtl/dma_ctrl_status.sv
// Our own choice: the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "dma_map.svh"

module dma_ctrl_status (
  input wire logic CLK_SYS,
  input wire logic RST_N,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [31:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic PREADY,
  output logic [31:0] PRDATA,
  output logic PSLVERR,
  input wire dma_pkg::engine_evt_t ENGINE_EVT,
  input wire dma_pkg::lane_t LANE,
  input wire dma_pkg::step_t STEP,
  output logic ENGINE_ENABLE,
  output logic TABLE_WALK,
  output logic DIRECTION,
  output logic [2:0] TABLE_FC,
  output logic [31:0] HOLD_DATA,
  output logic IRQ_REQ,
  output logic [2:0] IRQ_LEVEL
);

  // flops, each named for the register field, pin or internal signal it holds
  logic rst_meta_q;
  logic rst_sync_n_q;
  // bus answer
  logic pready_q;
  logic pslverr_q;
  logic [31:0] prdata_q;
  // interrupt control
  logic [2:0] level_q;
  logic ien_q;
  logic pend_q;
  logic trig_q;
  // control and status
  logic en_q;
  logic tw_q;
  logic dir_q;
  logic [3:0] err_q;
  logic done_q;
  // holding status
  logic [3:0] full_q;
  logic [3:0] inc_q;
  logic [31:0] hold_q;
  // function code and global gate
  logic [2:0] fc_q;
  logic gate_q;
  // interrupt request pins
  logic irq_q;
  logic [2:0] irq_lvl_q;

  // decode nets
  logic [29:0] widx;
  logic hit_ic;
  logic hit_cs;
  logic hit_hs;
  logic hit_fc;
  logic hit_gc;
  logic hit_any;
  // handshake and event nets
  logic access;
  logic wr_fire;
  logic [7:0] wbyte;
  logic trig;
  logic stop_evt;
  logic [3:0] err_evt;
  logic [7:0] rd_byte;

  // reset released through two flops, asserted at once
  // a raw release near an edge could leave some flops in reset and
  // others not; the copy lifts cleanly two edges after the pin
  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      rst_meta_q <= 1'b0;
      rst_sync_n_q <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_sync_n_q <= rst_meta_q;
    end
  end

  // word decode; upper index bits beyond the 30-bit word address drop out
  // four times an index wraps past 32 bits, so the top two index bits
  // cannot be seen on the bus and are simply dropped
  // an address that hits none of the five words answers with an error
  assign widx = PADDR[31:2];
  assign hit_ic = widx == 30'(`IDX_IRQ_CTRL);
  assign hit_cs = widx == 30'(`IDX_CTRL_STAT);
  assign hit_hs = widx == 30'(`IDX_HOLD_STAT);
  assign hit_fc = widx == 30'(`IDX_TABLE_FC);
  assign hit_gc = widx == 30'(`IDX_GEN_CTRL);
  assign hit_any = hit_ic | hit_cs | hit_hs | hit_fc | hit_gc;
  assign access = PSEL & PENABLE;
  assign wr_fire = access & PWRITE & pready_q;
  assign wbyte = PWDATA[7:0];

  // read mux; reserved bits come back as zero
  // the byte is captured in the first access cycle, so it shows the
  // state one edge before any write of the same access lands
  always_comb begin
    rd_byte = `RST_BYTE;
    if (hit_ic) begin
      rd_byte = {pend_q, 3'h0, ien_q, level_q};
    end else if (hit_cs) begin
      rd_byte = {done_q, err_q[3:0], dir_q, tw_q, en_q};
    end else if (hit_hs) begin
      rd_byte = {inc_q, full_q};
    end else if (hit_fc) begin
      rd_byte = {5'h00, fc_q};
    end else if (hit_gc) begin
      rd_byte = {3'h0, gate_q, 4'h0};
    end
  end

  // one wait state so read data and ready both leave flops
  // ready rises in the second access cycle and drops the edge after;
  // the trade is one extra cycle per access for clean flop outputs
  // a write lands only on the edge that samples ready high
  always_ff @(posedge CLK_SYS or negedge rst_sync_n_q) begin
    if (!rst_sync_n_q) begin
      pready_q <= 1'b0;
      prdata_q <= `RST_WORD;
      pslverr_q <= 1'b0;
    end else begin
      pready_q <= access & ~pready_q;
      if (access & ~pready_q) begin
        prdata_q <= PWRITE ? `RST_WORD : {24'h000000, rd_byte};
        pslverr_q <= ~hit_any;
      end else begin
        prdata_q <= `RST_WORD;
        pslverr_q <= 1'b0;
      end
    end
  end

  // level and enable fields of the interrupt control register
  // a level of zero is kept and read back, but never requests;
  // that leaves the done bit for polling software
  always_ff @(posedge CLK_SYS or negedge rst_sync_n_q) begin
    if (!rst_sync_n_q) begin
      level_q <= `RST_LEVEL;
      ien_q <= 1'b0;
    end else if (wr_fire & hit_ic) begin
      level_q <= wbyte[`IC_LEVEL_LSB +: 3];
      ien_q <= wbyte[`IC_ENABLE_BIT];
    end
  end

  // leading edge of enable AND done
  // trig_q holds the last value, so a product that stays high makes
  // only one edge; a fresh edge needs the product to fall first,
  // which a disable of the engine or of the interrupt gives
  assign trig = ien_q & done_q;

  always_ff @(posedge CLK_SYS or negedge rst_sync_n_q) begin
    if (!rst_sync_n_q) begin
      trig_q <= 1'b0;
    end else begin
      trig_q <= trig;
    end
  end

  // pending flag; a fresh edge beats a write-one in the same cycle
  // losing that edge would hide a finished transfer for good
  // clearing the enable drops the product too, so the two never meet
  // a write-one only clears; writing zero leaves the flag alone
  always_ff @(posedge CLK_SYS or negedge rst_sync_n_q) begin
    if (!rst_sync_n_q) begin
      pend_q <= 1'b0;
    end else if (trig & ~trig_q) begin
      pend_q <= 1'b1;
    end else if (~ien_q) begin
      pend_q <= 1'b0;
    end else if (wr_fire & hit_ic & wbyte[`IC_PENDING_BIT]) begin
      pend_q <= 1'b0;
    end
  end

  // read-write controls; status bits are never written
  // the engine reads these straight from the output pins
  // changing mode or direction mid-transfer is left to software
  always_ff @(posedge CLK_SYS or negedge rst_sync_n_q) begin
    if (!rst_sync_n_q) begin
      en_q <= 1'b0;
      tw_q <= 1'b0;
      dir_q <= 1'b0;
    end else if (wr_fire & hit_cs) begin
      en_q <= wbyte[`CS_ENABLE_BIT];
      tw_q <= wbyte[`CS_TW_BIT];
      dir_q <= wbyte[`CS_DIR_BIT];
    end
  end

  // any reported error also stops the engine
  // so every error report also raises the done bit, and a single
  // poll of the done bit covers both endings
  assign stop_evt = ENGINE_EVT.complete | ENGINE_EVT.berr_table |
                    ENGINE_EVT.berr_data | ENGINE_EVT.table_not32 |
                    ENGINE_EVT.port_8bit;

  // error reports in status bit order, table bus error lowest
  assign err_evt[0] = ENGINE_EVT.berr_table;
  assign err_evt[1] = ENGINE_EVT.berr_data;
  assign err_evt[2] = ENGINE_EVT.table_not32;
  assign err_evt[3] = ENGINE_EVT.port_8bit;

  // sticky error bits, held until the engine is disabled
  // software cannot clear one alone; only a disable wipes them all
  genvar b;
  generate
    for (b = 0; b < 4; b++) begin : g_err
      always_ff @(posedge CLK_SYS or negedge rst_sync_n_q) begin
        if (!rst_sync_n_q) begin
          err_q[b] <= 1'b0;
        end else if (~en_q) begin
          err_q[b] <= 1'b0;
        end else if (err_evt[b]) begin
          err_q[b] <= 1'b1;
        end
      end
    end
  endgenerate

  // done bit; events while disabled are dropped, engine is idle then
  // a stop and a disable in one cycle leave done clear: the disable
  // is the newer intent of software
  always_ff @(posedge CLK_SYS or negedge rst_sync_n_q) begin
    if (!rst_sync_n_q) begin
      done_q <= 1'b0;
    end else if (~en_q) begin
      done_q <= 1'b0;
    end else if (stop_evt) begin
      done_q <= 1'b1;
    end
  end

  // holding register lanes; a fill beats a drain in the same cycle
  // disable clears only the full flags; the data bytes stay put,
  // so a late look at the holding data still shows the last bytes
  genvar i;
  generate
    for (i = 0; i < 4; i++) begin : g_lane
      always_ff @(posedge CLK_SYS or negedge rst_sync_n_q) begin
        if (!rst_sync_n_q) begin
          full_q[i] <= 1'b0;
          hold_q[i*8 +: 8] <= `RST_BYTE;
        end else if (~en_q) begin
          full_q[i] <= 1'b0;
        end else if (LANE.wr[i]) begin
          full_q[i] <= 1'b1;
          hold_q[i*8 +: 8] <= LANE.data[i*8 +: 8];
        end else if (LANE.rd[i]) begin
          full_q[i] <= 1'b0;
        end
      end
    end
  endgenerate

  // last step size kept one-hot
  // shifting one by the size code cannot set two bits, so the field
  // is one-hot by construction once any step has been taken
  always_ff @(posedge CLK_SYS or negedge rst_sync_n_q) begin
    if (!rst_sync_n_q) begin
      inc_q <= 4'h0;
    end else if (~en_q) begin
      inc_q <= 4'h0;
    end else if (STEP.valid) begin
      inc_q <= 4'h1 << STEP.size;
    end
  end

  // table fetch function code
  // stored as written; only a few codes make table walking work,
  // and nothing here refuses the others
  always_ff @(posedge CLK_SYS or negedge rst_sync_n_q) begin
    if (!rst_sync_n_q) begin
      fc_q <= 3'h0;
    end else if (wr_fire & hit_fc) begin
      fc_q <= wbyte[2:0];
    end
  end

  // global interrupt gate; other bits of that register live elsewhere
  // with the gate low pending still sets, it just raises no request,
  // so opening the gate later releases a waiting interrupt
  always_ff @(posedge CLK_SYS or negedge rst_sync_n_q) begin
    if (!rst_sync_n_q) begin
      gate_q <= 1'b0;
    end else if (wr_fire & hit_gc) begin
      gate_q <= wbyte[`GC_GLOBAL_GATE_BIT];
    end
  end

  // request leaves a flop, so it trails the pending flag by one cycle
  // level reads zero whenever the request is low, so a consumer may
  // latch the level on the request's rising edge alone
  always_ff @(posedge CLK_SYS or negedge rst_sync_n_q) begin
    if (!rst_sync_n_q) begin
      irq_q <= 1'b0;
      irq_lvl_q <= `RST_LEVEL;
    end else if (pend_q & ien_q & gate_q & (level_q != 3'h0)) begin
      irq_q <= 1'b1;
      irq_lvl_q <= level_q;
    end else begin
      irq_q <= 1'b0;
      irq_lvl_q <= `RST_LEVEL;
    end
  end

  // outputs straight from flops
  // no logic between these flops and the pins, so no glitches leave
  assign PREADY = pready_q;
  assign PRDATA = prdata_q;
  assign PSLVERR = pslverr_q;
  assign ENGINE_ENABLE = en_q;
  assign TABLE_WALK = tw_q;
  assign DIRECTION = dir_q;
  assign TABLE_FC = fc_q;
  assign HOLD_DATA = hold_q;
  assign IRQ_REQ = irq_q;
  assign IRQ_LEVEL = irq_lvl_q;

endmodule // dma_ctrl_status

`default_nettype wire

//--- rtl/dma_map.svh
`ifndef DMA_MAP_SVH
`define DMA_MAP_SVH

// register word indices; byte address is four times the index
`define IDX_IRQ_CTRL 32'hFFFE1020
`define IDX_CTRL_STAT 32'hFFFE1021
`define IDX_HOLD_STAT 32'hFFFE1023
`define IDX_TABLE_FC 32'hFFFE1025
`define IDX_GEN_CTRL 32'hFFFE1027

// interrupt control fields
`define IC_LEVEL_LSB 0
`define IC_ENABLE_BIT 3
`define IC_PENDING_BIT 7

// control/status fields
`define CS_ENABLE_BIT 0
`define CS_TW_BIT 1
`define CS_DIR_BIT 2
`define CS_TBL_BERR_BIT 3
`define CS_DATA_BERR_BIT 4
`define CS_TBL_SIZE_BIT 5
`define CS_PORT8_BIT 6
`define CS_DONE_BIT 7

// general control field
`define GC_GLOBAL_GATE_BIT 4

// reset values
`define RST_BYTE 8'h00
`define RST_LEVEL 3'h0
`define RST_WORD 32'h0000_0000

`endif

//--- rtl/dma_pkg.sv
`default_nettype none
package dma_pkg;

  // error and completion reports from the transfer engine
  typedef struct packed {
    logic complete;
    logic berr_table;
    logic berr_data;
    logic table_not32;
    logic port_8bit;
  } engine_evt_t;

  // byte lane traffic of the holding register
  typedef struct packed {
    logic [3:0] wr;
    logic [3:0] rd;
    logic [31:0] data;
  } lane_t;

  // counter step; size 0..3 means increment 1, 2, 4 or 8
  typedef struct packed {
    logic valid;
    logic [1:0] size;
  } step_t;

endpackage

`default_nettype wire
